// *** include/sswe_pkg.sv ***
// package for the socket status, interrupt routing and window enable block
package sswe_pkg;
   // register byte addresses (word aligned)
   localparam logic [3:0] ADDR_STATUS_CHANGE = 4'h0;
   localparam logic [3:0] ADDR_IRQ_CONFIG = 4'h4;
   localparam logic [3:0] ADDR_DETECT_CTRL = 4'h8;
   localparam logic [3:0] ADDR_GLOBAL_CTRL = 4'hc;
   localparam logic [3:0] ADDR_WINDOW_EN = 4'h0;
   localparam logic [3:0] ADDR_INT_GEN_CTRL = 4'h4;
   localparam logic [3:0] ADDR_IO_CTRL = 4'h8;
   localparam logic [3:0] ADDR_CARD_STATE = 4'hc;
   // byte address bit 4 selects the second bank of four words
   localparam int ADDR_BANK_BIT = 4;
   localparam int ADDR_WIDTH = 5;

   // reset values
   localparam logic [7:0] IRQ_CONFIG_RST = 8'h00;
   localparam logic [7:0] DETECT_CTRL_RST = 8'h00;
   localparam logic [7:0] GLOBAL_CTRL_RST = 8'h00;
   localparam logic [7:0] WINDOW_EN_RST = 8'h00;
   localparam logic [7:0] INT_GEN_CTRL_RST = 8'h00;
   localparam logic [7:0] IO_CTRL_RST = 8'h00;

   // field positions
   localparam int ROUTE_LSB = 4;
   localparam int EN_DETECT = 3;
   localparam int EN_READY = 2;
   localparam int EN_BWARN = 1;
   localparam int EN_BFAIL = 0;
   localparam int DC_VSENSE_LSB = 6;
   localparam int DC_SW_DETECT = 5;
   localparam int DC_RESUME_EN = 4;
   localparam int DC_REMOVAL_CLR = 1;
   localparam int GC_LEVEL_SEL = 3;
   localparam int GC_WB_ACK = 2;
   localparam int GC_LEVEL_IRQ = 1;
   localparam int IGC_RING_EN = 7;
   localparam int IGC_IO_CARD = 5;
   localparam logic [7:0] WINDOW_EN_MASK = 8'hdf;
   localparam logic [7:0] DETECT_CTRL_MASK = 8'h1f;
   localparam logic [7:0] GLOBAL_CTRL_MASK = 8'h0f;
   localparam logic [7:0] SW_DETECT_MASK = 8'hdf;
   localparam int NUM_ISA = 16;

   typedef struct packed {
      logic detect_a_n;
      logic detect_b_n;
      logic ready_busy;
      logic batt1_or_statchg_n;
      logic batt2;
      logic [1:0] voltage_sense_state;
   } sswe_card_s;

   typedef struct packed {
      logic [1:0] io_hit;
      logic [4:0] mem_hit;
      logic strobe;
   } sswe_access_s;
endpackage

// *** logic/sswe_socket_ctrl.sv ***
// socket status change interrupt, card detect control and window enable registers
`timescale 1ns/1ns
module sswe_socket_ctrl (
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic [sswe_pkg::ADDR_WIDTH-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   input wire sswe_pkg::sswe_card_s card_in,
   input wire logic batt_warn_in,
   input wire logic batt_fail_in,
   input wire sswe_pkg::sswe_access_s access_in,
   output logic card_enable_out,
   output logic ring_wake_out_n,
   output logic pci_irq_out_n,
   output logic [sswe_pkg::NUM_ISA-1:0] isa_irq_line_out,
   output logic [sswe_pkg::NUM_ISA-1:0] isa_irq_line_oe_out,
   output logic config_clear_out,
   output logic [7:0] io_ctrl_out
);
   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_ACK = 3'b010,
      BUS_DONE = 3'b100
   } sswe_bus_e;

   // isa line number selected by routing code, zero when pci line
   function automatic logic [3:0] route_line(input logic [3:0] code);
      case (code)
         4'h3, 4'h4, 4'h5, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf: route_line = code;
         default: route_line = 4'h0;
      endcase
   endfunction

   sswe_bus_e bus_state, next_bus_state;
   logic [7:0] irq_config, next_irq_config;
   logic [7:0] detect_ctrl, next_detect_ctrl;
   logic [7:0] global_ctrl, next_global_ctrl;
   logic [7:0] window_en, next_window_en;
   logic [7:0] int_gen_ctrl, next_int_gen_ctrl;
   logic [7:0] io_ctrl, next_io_ctrl;
   logic [3:0] status, next_status;
   logic [1:0] vsense, next_vsense;
   logic ring_low, next_ring_low;
   logic [31:0] rdata, next_rdata;
   logic [2:0] card_prev, next_card_prev;
   logic irq_req, irq_prev, next_irq_prev;
   logic [sswe_pkg::NUM_ISA-1:0] isa_out, next_isa_out, isa_oe, next_isa_oe;
   logic pci_n, next_pci_n;
   logic card_en_q, next_card_en_q;
   logic clr_q, next_clr_q;

   logic io_mode, detect_chg, ready_rise, removed, removal_clr, bus_fire;
   logic wr_hit, rd_hit, bank;
   logic [1:0] waddr;
   logic [3:0] events, line;

   assign io_mode = int_gen_ctrl[sswe_pkg::IGC_IO_CARD];
   assign detect_chg = (card_in.detect_a_n != card_prev[2]) |
                       (card_in.detect_b_n != card_prev[1]);
   assign ready_rise = card_in.ready_busy & ~card_prev[0];
   assign removed = card_in.detect_a_n & card_in.detect_b_n & ~(card_prev[2] & card_prev[1]);
   assign removal_clr = removed & detect_ctrl[sswe_pkg::DC_REMOVAL_CLR];
   assign bus_fire = (bus_state == BUS_ACK);
   assign bank = avs_address_in[sswe_pkg::ADDR_BANK_BIT];
   assign waddr = avs_address_in[3:2];
   assign wr_hit = bus_fire & avs_write_in & avs_byteenable_in[0];
   assign rd_hit = bus_fire & avs_read_in;

   // event sources gated by their enables; ready and battery warn also by the card mode, which switches battery fail to status change
   always_comb begin
      events = 4'h0;
      events[3] = irq_config[sswe_pkg::EN_DETECT] & detect_chg;
      events[2] = irq_config[sswe_pkg::EN_READY] & ~io_mode & ready_rise;
      events[1] = irq_config[sswe_pkg::EN_BWARN] & ~io_mode & batt_warn_in;
      events[0] = irq_config[sswe_pkg::EN_BFAIL] &
                  (io_mode ? (~card_in.batt1_or_statchg_n & ~int_gen_ctrl[sswe_pkg::IGC_RING_EN])
                           : batt_fail_in);
   end

   assign irq_req = |(status & irq_config[3:0]);
   assign line = route_line(irq_config[7:4]);

   // bus handshake: one wait cycle, then ack, then release
   always_comb begin
      next_bus_state = bus_state;
      unique case (bus_state)
         BUS_IDLE: if (avs_read_in | avs_write_in) next_bus_state = BUS_ACK;
         BUS_ACK: next_bus_state = BUS_DONE;
         BUS_DONE: next_bus_state = BUS_IDLE;
      endcase
   end
   assign avs_waitrequest_out = ~bus_fire;

   always_comb begin
      next_irq_config = irq_config;
      next_detect_ctrl = detect_ctrl;
      next_global_ctrl = global_ctrl;
      next_window_en = window_en;
      next_int_gen_ctrl = int_gen_ctrl;
      next_io_ctrl = io_ctrl;
      next_status = status;
      next_rdata = rdata;
      if (wr_hit) begin
         if (!bank) begin
            unique case (waddr)
               2'd1: next_irq_config = avs_writedata_in[7:0];
               2'd2: next_detect_ctrl = avs_writedata_in[7:0] & sswe_pkg::DETECT_CTRL_MASK;
               2'd3: next_global_ctrl = avs_writedata_in[7:0] & sswe_pkg::GLOBAL_CTRL_MASK;
               2'd0: if (global_ctrl[sswe_pkg::GC_WB_ACK])
                  next_status = status & ~avs_writedata_in[3:0];
            endcase
         end else begin
            unique case (waddr)
               2'd0: next_window_en = avs_writedata_in[7:0];
               2'd1: next_int_gen_ctrl = avs_writedata_in[7:0];
               2'd2: next_io_ctrl = avs_writedata_in[7:0];
               2'd3: ;
            endcase
         end
      end
      if (rd_hit) begin
         next_rdata = 32'h0;
         if (!bank) begin
            unique case (waddr)
               2'd0: begin
                  next_rdata[3:0] = status & irq_config[3:0];
                  if (!global_ctrl[sswe_pkg::GC_WB_ACK]) next_status = 4'h0;
               end
               2'd1: next_rdata[7:0] = irq_config;
               2'd2: next_rdata[7:0] = {vsense, 1'b0, detect_ctrl[4:0]};
               2'd3: next_rdata[7:0] = global_ctrl;
            endcase
         end else begin
            unique case (waddr)
               2'd0: next_rdata[7:0] = window_en;
               2'd1: next_rdata[7:0] = int_gen_ctrl;
               2'd2: next_rdata[7:0] = io_ctrl;
               2'd3: next_rdata[7:0] = {1'b0, ring_low, card_in.detect_b_n, card_in.detect_a_n,
                                        irq_req, line[2:0]};
            endcase
         end
      end
      // software detect: writing one sets the detect change event, status bit 3
      if (wr_hit && !bank && waddr == 2'd2 && avs_writedata_in[sswe_pkg::DC_SW_DETECT])
         next_status[3] = 1'b1;
      next_status = next_status | events; // set wins over clear
      if (removal_clr) begin
         next_irq_config[7:4] = 4'h0;
         next_int_gen_ctrl = sswe_pkg::INT_GEN_CTRL_RST;
         next_window_en = sswe_pkg::WINDOW_EN_RST;
         next_io_ctrl = sswe_pkg::IO_CTRL_RST;
      end
   end

   // card side outputs and isa line driving
   always_comb begin
      next_card_prev = {card_in.detect_a_n, card_in.detect_b_n, card_in.ready_busy};
      next_vsense = card_in.voltage_sense_state;
      next_ring_low = ring_low;
      if (detect_chg && detect_ctrl[sswe_pkg::DC_RESUME_EN]) next_ring_low = 1'b1;
      if (!detect_ctrl[sswe_pkg::DC_RESUME_EN]) next_ring_low = 1'b0;
      next_irq_prev = irq_req;
      next_pci_n = ~(irq_req & (line == 4'h0));
      next_isa_out = '0;
      next_isa_oe = '0;
      if (line != 4'h0) begin
         next_isa_oe[line] = global_ctrl[sswe_pkg::GC_LEVEL_IRQ] ? irq_req : 1'b1;
         next_isa_out[line] = global_ctrl[sswe_pkg::GC_LEVEL_IRQ] ? 1'b0 : irq_req;
      end
      next_card_en_q = access_in.strobe &
                       (|(access_in.io_hit & window_en[7:6]) |
                        |(access_in.mem_hit & window_en[4:0]));
      next_clr_q = removal_clr;
   end

   always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
         bus_state <= BUS_IDLE;
         irq_config <= sswe_pkg::IRQ_CONFIG_RST;
         detect_ctrl <= sswe_pkg::DETECT_CTRL_RST;
         global_ctrl <= sswe_pkg::GLOBAL_CTRL_RST;
         window_en <= sswe_pkg::WINDOW_EN_RST;
         int_gen_ctrl <= sswe_pkg::INT_GEN_CTRL_RST;
         io_ctrl <= sswe_pkg::IO_CTRL_RST;
         status <= 4'h0;
         vsense <= 2'b00;
         ring_low <= 1'b0;
         rdata <= 32'h0;
         card_prev <= 3'b110;
         irq_prev <= 1'b0;
         isa_out <= '0;
         isa_oe <= '0;
         pci_n <= 1'b1;
         card_en_q <= 1'b0;
         clr_q <= 1'b0;
      end else begin
         bus_state <= next_bus_state;
         irq_config <= next_irq_config;
         detect_ctrl <= next_detect_ctrl;
         global_ctrl <= next_global_ctrl;
         window_en <= next_window_en & sswe_pkg::WINDOW_EN_MASK;
         int_gen_ctrl <= next_int_gen_ctrl;
         io_ctrl <= next_io_ctrl;
         status <= next_status;
         vsense <= next_vsense;
         ring_low <= next_ring_low;
         rdata <= next_rdata;
         card_prev <= next_card_prev;
         irq_prev <= next_irq_prev;
         isa_out <= next_isa_out;
         isa_oe <= next_isa_oe;
         pci_n <= next_pci_n;
         card_en_q <= next_card_en_q;
         clr_q <= next_clr_q;
      end
   end

   // read data presented combinationally in the ack cycle from live state
   always_comb begin
      avs_readdata_out = 32'h0;
      if (!bank) begin
         unique case (waddr)
            2'd0: avs_readdata_out[3:0] = status & irq_config[3:0];
            2'd1: avs_readdata_out[7:0] = irq_config;
            2'd2: avs_readdata_out[7:0] = {vsense, 1'b0, detect_ctrl[4:0]};
            2'd3: avs_readdata_out[7:0] = global_ctrl;
         endcase
      end else begin
         unique case (waddr)
            2'd0: avs_readdata_out[7:0] = window_en;
            2'd1: avs_readdata_out[7:0] = int_gen_ctrl;
            2'd2: avs_readdata_out[7:0] = io_ctrl;
            2'd3: avs_readdata_out[7:0] = {1'b0, ring_low, card_in.detect_b_n,
                                          card_in.detect_a_n, irq_req, line[2:0]};
         endcase
      end
   end

   assign ring_wake_out_n = ~ring_low;
   assign pci_irq_out_n = pci_n;
   assign isa_irq_line_out = isa_out;
   assign isa_irq_line_oe_out = isa_oe;
   assign card_enable_out = card_en_q;
   assign config_clear_out = clr_q;
   assign io_ctrl_out = io_ctrl;
endmodule

// *** test/sswe_card_model.sv ***
// behavioural model of a 16-bit card seated in the socket
`timescale 1ns/1ns
module sswe_card_model (
   input wire logic clock_in,
   input wire logic present_in,
   input wire logic ready_in,
   input wire logic statchg_in,
   input wire logic [1:0] vsense_in,
   output sswe_pkg::sswe_card_s card_out
);
   logic seated = 1'b0;
   // second detect pin makes contact a cycle after the first
   always_ff @(posedge clock_in) seated <= present_in;
   // empty socket: pulled-up detect lines and batt1_or_statchg_n read high, ready_busy and batt2 low
   always_comb begin
      card_out.detect_a_n = !present_in;
      card_out.detect_b_n = !seated;
      card_out.ready_busy = present_in & ready_in;
      card_out.batt1_or_statchg_n = !(present_in & statchg_in);
      card_out.batt2 = present_in;
      card_out.voltage_sense_state = present_in ? vsense_in : 2'h0;
   end
endmodule

// *** test/sswe_socket_ctrl_bench.sv ***
// self-checking bench for the socket control block
`timescale 1ns/1ns
module sswe_socket_ctrl_bench;
   localparam logic [15:0] LINES = 16'hdeb8;
   logic clock_in, resetn_in, avs_read_in, avs_write_in, batt_warn_in, batt_fail_in;
   logic present, ready, statchg, avs_waitrequest_out, card_enable_out, ring_wake_out_n;
   logic pci_irq_out_n, config_clear_out;
   logic [4:0] avs_address_in;
   logic [31:0] avs_writedata_in, avs_readdata_out;
   logic [3:0] avs_byteenable_in;
   logic [1:0] vs;
   logic [7:0] hit, io_ctrl_out;
   logic [15:0] isa_irq_line_out, isa_irq_line_oe_out;
   sswe_pkg::sswe_card_s card_in;
   sswe_pkg::sswe_access_s access_in;
   int num_errors, n_checks;
   sswe_socket_ctrl sswe_socket_ctrl_inst (.clock_in, .resetn_in, .avs_address_in,
      .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
      .avs_waitrequest_out, .card_in, .batt_warn_in, .batt_fail_in, .access_in,
      .card_enable_out, .ring_wake_out_n, .pci_irq_out_n, .isa_irq_line_out,
      .isa_irq_line_oe_out, .config_clear_out, .io_ctrl_out);
   sswe_card_model sswe_card_model_inst (.clock_in, .present_in(present), .ready_in(ready),
      .statchg_in(statchg), .vsense_in(vs), .card_out(card_in));
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic chk_pin(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   // request held until the edge that samples waitrequest low
   task automatic bus(input logic r, input logic [4:0] a, input logic [7:0] d,
      output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clock_in);
      avs_address_in <= a;
      avs_writedata_in <= {24'h0, d};
      avs_read_in <= r;
      avs_write_in <= !r;
      // waitrequest and read data are read as they stand at the sampling edge
      do begin
         @(posedge clock_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 40);
      if (avs_waitrequest_out !== 1'b0) begin
         num_errors++;
         summarize();
      end
      q = avs_readdata_out[7:0];
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      @(posedge clock_in);
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b0, a, d, q);
   endtask
   task automatic rd_chk(input string name, input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b1, a, 8'h00, q);
      chk_reg(name, exp, q);
   endtask
   task automatic neg(input int c);
      repeat (c) @(negedge clock_in);
   endtask
   task automatic step(input int c);
      repeat (c) @(posedge clock_in);
   endtask
   initial begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end
   initial begin
      num_errors = 0;
      n_checks = 0;
      {resetn_in, avs_read_in, avs_write_in, batt_warn_in, batt_fail_in} = '0;
      {present, ready, statchg, avs_address_in, avs_writedata_in} = '0;
      avs_byteenable_in = 4'hf;
      vs = 2'h2;
      access_in = '0;
      step(3);
      resetn_in <= 1'b1;
      neg(1);
      chk_pin("ring wake", 16'h1, 16'(ring_wake_out_n));
      chk_pin("pci irq", 16'h1, 16'(pci_irq_out_n));
      chk_pin("isa enables", 16'h0, isa_irq_line_oe_out);
      rd_chk("irq config", 5'h04, 8'h00);
      rd_chk("detect control", 5'h08, 8'h00);
      rd_chk("global control", 5'h0c, 8'h00);
      rd_chk("window enable", 5'h10, 8'h00);
      wr(5'h0c, 8'hff);
      rd_chk("global control", 5'h0c, 8'h0f);
      avs_byteenable_in <= 4'he;
      wr(5'h0c, 8'h00);
      avs_byteenable_in <= 4'hf;
      rd_chk("global control", 5'h0c, 8'h0f);
      wr(5'h10, 8'hff);
      wr(5'h1c, 8'h00);
      rd_chk("window enable", 5'h10, 8'hdf);
      $display("test registers done");
      for (int i = 0; i < 8; i++) begin
         if (i == 5) continue;
         hit = (i > 5) ? 8'h01 << i : 8'h02 << i;
         wr(5'h10, 8'h01 << i);
         access_in <= sswe_pkg::sswe_access_s'(hit | 8'h01);
         neg(2);
         chk_pin("card enable", 16'h1, 16'(card_enable_out));
         step(1);
         access_in <= sswe_pkg::sswe_access_s'(~hit);
         neg(2);
         chk_pin("card enable", 16'h0, 16'(card_enable_out));
      end
      $display("test windows done");
      wr(5'h0c, 8'h00);
      wr(5'h04, 8'h08);
      wr(5'h08, 8'h20);
      for (int c = 0; c < 16; c++) begin
         wr(5'h04, {4'(c), 4'h8});
         neg(3);
         chk_pin("pci irq", {15'h0, LINES[c]}, 16'(pci_irq_out_n));
         chk_pin("isa enable", LINES[c] ? 16'h1 << c : 16'h0, isa_irq_line_oe_out);
         chk_pin("isa level", isa_irq_line_oe_out, isa_irq_line_out);
      end
      wr(5'h04, 8'h58);
      wr(5'h0c, 8'h02);
      neg(3);
      chk_pin("level drive", 16'h0020, isa_irq_line_oe_out);
      chk_pin("level low", 16'h0, isa_irq_line_out);
      rd_chk("status", 5'h00, 8'h08);
      rd_chk("status", 5'h00, 8'h00);
      neg(3);
      chk_pin("level released", 16'h0, isa_irq_line_oe_out);
      wr(5'h0c, 8'h00);
      neg(3);
      chk_pin("edge enable", 16'h0020, isa_irq_line_oe_out);
      chk_pin("edge idle", 16'h0, isa_irq_line_out);
      $display("test routing done");
      wr(5'h0c, 8'h04);
      wr(5'h04, 8'h0f);
      present <= 1'b1;
      step(4);
      ready <= 1'b1;
      step(4);
      rd_chk("status", 5'h00, 8'h0c);
      rd_chk("status", 5'h00, 8'h0c);
      wr(5'h00, 8'h08);
      rd_chk("status", 5'h00, 8'h04);
      neg(2);
      chk_pin("pci irq", 16'h0, 16'(pci_irq_out_n));
      wr(5'h00, 8'h04);
      rd_chk("status", 5'h00, 8'h00);
      neg(3);
      chk_pin("pci irq", 16'h1, 16'(pci_irq_out_n));
      batt_warn_in <= 1'b1;
      batt_fail_in <= 1'b1;
      step(3);
      {batt_warn_in, batt_fail_in} <= 2'b00;
      rd_chk("status", 5'h00, 8'h03);
      wr(5'h00, 8'h03);
      wr(5'h14, 8'h20);
      ready <= 1'b0;
      step(3);
      {ready, batt_warn_in, statchg} <= 3'b111;
      step(3);
      batt_warn_in <= 1'b0;
      rd_chk("status", 5'h00, 8'h01);
      wr(5'h04, 8'h0e);
      rd_chk("status", 5'h00, 8'h00);
      $display("test acknowledge done");
      statchg <= 1'b0;
      wr(5'h0c, 8'h00);
      wr(5'h04, 8'h5f);
      wr(5'h18, 8'h55);
      wr(5'h10, 8'hff);
      wr(5'h08, 8'h12);
      rd_chk("detect control", 5'h08, 8'h92);
      present <= 1'b0;
      for (int k = 0; k < 20 && config_clear_out !== 1'b1; k++) @(negedge clock_in);
      chk_pin("clear pulse", 16'h1, 16'(config_clear_out));
      neg(2);
      chk_pin("ring wake", 16'h0, 16'(ring_wake_out_n));
      chk_pin("io control", 16'h0, 16'(io_ctrl_out));
      rd_chk("irq config", 5'h04, 8'h0f);
      rd_chk("window enable", 5'h10, 8'h00);
      rd_chk("int gen control", 5'h14, 8'h00);
      rd_chk("detect control", 5'h08, 8'h12);
      $display("test removal done");
      summarize();
   end
endmodule

// *** test/sswe_socket_ctrl_chk.sv ***
// assertion checker for the socket control block
`timescale 1ns/1ns
module sswe_socket_ctrl_chk (
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic [sswe_pkg::ADDR_WIDTH-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire sswe_pkg::sswe_card_s card_in,
   input wire sswe_pkg::sswe_access_s access_in,
   input wire logic card_enable_out,
   input wire logic pci_irq_out_n,
   input wire logic [sswe_pkg::NUM_ISA-1:0] isa_irq_line_oe_out,
   input wire logic config_clear_out
);
   localparam logic [15:0] LINES = 16'hdeb8;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!resetn_in);
   logic rd_ack;
   assign rd_ack = avs_read_in && !avs_waitrequest_out;
   sequence req_start;
      $rose(avs_read_in || avs_write_in);
   endsequence
   sequence ack_cycle;
      !avs_waitrequest_out ##1 avs_waitrequest_out;
   endsequence
   bus_ack_a: assert property (req_start |=> ack_cycle)
      else $error("bus answer not a single cycle one cycle after request");
   global_zero_a: assert property (rd_ack && (avs_address_in & 5'h1c) == 5'h0c
      |-> avs_readdata_out[7:4] == 4'h0) else $error("global control upper bits not zero");
   sw_detect_a: assert property (rd_ack && (avs_address_in & 5'h1c) == 5'h08
      |-> !avs_readdata_out[5]) else $error("software detect bit read as one");
   vsense_a: assert property (rd_ack && (avs_address_in & 5'h1c) == 5'h08
      && $stable(card_in.voltage_sense_state)
      |-> avs_readdata_out[7:6] == card_in.voltage_sense_state)
      else $error("voltage sense bits differ from inputs");
   pci_excl_a: assert property (!pci_irq_out_n |-> isa_irq_line_oe_out == '0)
      else $error("isa line driven while routed to pci");
   line_valid_a: assert property ($onehot0(isa_irq_line_oe_out)
      && (isa_irq_line_oe_out & ~LINES) == '0) else $error("isa line not a valid choice");
   card_en_a: assert property (card_enable_out |-> $past(access_in.strobe)
      && $past(access_in[7:1]) != 7'h00) else $error("card enable without window access");
   clear_pulse_a: assert property (config_clear_out
      |-> card_in.detect_a_n && card_in.detect_b_n ##1 !config_clear_out)
      else $error("config clear not a single pulse on removal");
endmodule
bind sswe_socket_ctrl sswe_socket_ctrl_chk sswe_socket_ctrl_chk_inst (.clock_in, .resetn_in,
   .avs_address_in, .avs_read_in, .avs_write_in, .avs_readdata_out, .avs_waitrequest_out,
   .card_in, .access_in, .card_enable_out, .pci_irq_out_n, .isa_irq_line_oe_out,
   .config_clear_out);
